/* File: hdl/enclave_page_metadata.sv */
/*
  Enclave page metadata block: captures the page-operation descriptor,
  decodes security metadata, checks access permissions, and sequences the
  paging crypto record for evict (write out) and reload (read and check).
  Assumes software-prepared structures arrive as 64-bit words with byte
  offsets, one word per cycle, and memory accepts each output word.
*/
// Contract
// - Descriptor bytes 0-7 hold linear address, 8-15 source page pointer.
// - Descriptor byte 16 holds pointer to metadata or crypto record.
// - Descriptor byte 24 holds address of the control page slot.
// - Metadata is flags word then 56 reserved bytes, zero required.
// - Reads inside enclave allowed only with flag bit 0.
// - Writes inside enclave allowed only with flag bit 1.
// - Instruction fetch allowed only with flag bit 2.
// - Flag bit 3 reports pending-acceptance state.
// - Flag bit 4 reports modified state.
// - Flag bit 5 reports permission restriction in progress.
// - Bits 15:8 hold page kind; bits 7:6 and 63:16 must be zero.
// - Codes 0,2,3,4 map to control, regular, version array, trimmed.
// - Codes 5,6 are shadow-stack pages only with the capability.
// - Crypto record is 128 bytes long.
// - Evict computes the authentication code and writes the whole record.
// - Both reload variants read the record and verify the code.
// - Record: metadata 0, identifier 64, zeros 72, code 112.
// - Code covers page contents, metadata and reserved record area.
module enclave_page_metadata (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [127:0] mac_key,
  input wire logic shadow_stack_cap,
  input wire logic desc_valid,
  input wire logic [7:0] desc_off,
  input wire logic [63:0] desc_word,
  input wire logic meta_valid,
  input wire logic [7:0] meta_off,
  input wire logic [63:0] meta_word,
  input wire logic access_req,
  input wire logic access_rd,
  input wire logic access_wr,
  input wire logic access_fetch,
  input wire logic op_start,
  input wire page_meta_pkg::page_op_t op_kind,
  input wire logic [63:0] enclave_id,
  input wire logic page_valid,
  input wire logic [63:0] page_word,
  input wire logic page_last,
  input wire logic rec_in_valid,
  input wire logic [63:0] rec_in_word,
  output logic [63:0] linear_addr,
  output logic [63:0] source_ptr,
  output logic [63:0] meta_ptr,
  output logic [63:0] ctrl_page_addr,
  output logic meta_ok,
  output logic pending,
  output logic modified,
  output logic perm_restrict_busy,
  output page_meta_pkg::page_kind_t page_kind,
  output logic access_grant,
  output logic access_deny,
  output logic rec_out_valid,
  output logic [7:0] rec_out_off,
  output logic [63:0] rec_out_word,
  output logic op_busy,
  output logic op_done,
  output logic op_fail
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_PAGE, ST_EMIT, ST_CHECK, ST_FINISH
  } seq_st_t;

  typedef struct packed {
    seq_st_t st;
    page_meta_pkg::page_op_t op;
    logic [63:0] lin;
    logic [63:0] src;
    logic [63:0] mptr;
    logic [63:0] cptr;
    logic [63:0] flags;
    logic rsvd_ok;
    logic [7:0] off;
    logic [127:0] mac_got;
    logic rec_ok;
    logic grant;
    logic deny;
    logic ovalid;
    logic [7:0] ooff;
    logic [63:0] oword;
    logic done;
    logic fail;
    // Registered status and busy outputs
    logic ok;
    logic pend;
    logic mod;
    logic prb;
    page_meta_pkg::page_kind_t kind;
    logic busy;
  } state_t;

  state_t s_q, s_d;
  mac_if mif ();

  page_mac_accum u_mac (
    .clk(clk),
    .rst_b(rst_b),
    .key(mac_key),
    .m(mif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic page_meta_pkg::page_kind_t kind_of(
    input logic [7:0] code, input logic ss);
    page_meta_pkg::page_kind_t k;
    k = page_meta_pkg::PK_RESERVED;
    unique case (code)
      page_meta_pkg::KIND_CONTROL_PAGE: k = page_meta_pkg::PK_CONTROL;
      page_meta_pkg::KIND_THREAD_CTRL_PAGE: k = page_meta_pkg::PK_THREAD;
      page_meta_pkg::KIND_REGULAR_PAGE: k = page_meta_pkg::PK_REGULAR;
      page_meta_pkg::KIND_VERSION_ARRAY: k = page_meta_pkg::PK_VERSION;
      page_meta_pkg::KIND_TRIMMED: k = page_meta_pkg::PK_TRIMMED;
      page_meta_pkg::KIND_SHADOW_STACK_HEAD:
        k = ss ? page_meta_pkg::PK_SS_HEAD : page_meta_pkg::PK_RESERVED;
      page_meta_pkg::KIND_SHADOW_STACK_TAIL:
        k = ss ? page_meta_pkg::PK_SS_TAIL : page_meta_pkg::PK_RESERVED;
      default: k = page_meta_pkg::PK_RESERVED;
    endcase
    return k;
  endfunction

  logic [7:0] kind_code;
  page_meta_pkg::page_kind_t kind_now;
  logic flags_ok;
  assign kind_code = s_q.flags[page_meta_pkg::KIND_LSB +: 8];
  assign kind_now =
    kind_of(kind_code, shadow_stack_cap);
  assign flags_ok =
    ((s_q.flags & page_meta_pkg::FLAG_RSVD_MASK) == '0) &&
    s_q.rsvd_ok &&
    (kind_now != page_meta_pkg::PK_RESERVED);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.grant = 1'b0;
    s_d.deny = 1'b0;
    s_d.ovalid = 1'b0;
    s_d.done = 1'b0;
    mif.clear = 1'b0;
    mif.absorb = 1'b0;
    mif.word = '0;

    // Status follows the captured flags one cycle later
    s_d.ok = flags_ok;
    s_d.pend = s_q.flags[page_meta_pkg::FLAG_PENDING];
    s_d.mod = s_q.flags[page_meta_pkg::FLAG_MODIFIED];
    s_d.prb = s_q.flags[page_meta_pkg::FLAG_RESTRICT_BUSY];
    s_d.kind = kind_now;

    // Descriptor capture
    if (desc_valid) begin
      unique case (desc_off)
        page_meta_pkg::DESC_LIN_OFF: s_d.lin = desc_word;
        page_meta_pkg::DESC_SRC_OFF: s_d.src = desc_word;
        page_meta_pkg::DESC_META_OFF: s_d.mptr = desc_word;
        page_meta_pkg::DESC_CTRL_OFF: s_d.cptr = desc_word;
        default: ;
      endcase
    end

    // Metadata capture outside record sequencing
    if (meta_valid && s_q.st == ST_IDLE) begin
      if (meta_off == page_meta_pkg::META_FLAGS_OFF) begin
        s_d.flags = meta_word;
        s_d.rsvd_ok = 1'b1;
      end else if (meta_off < page_meta_pkg::META_BYTES &&
                   meta_word != '0) begin
        s_d.rsvd_ok = 1'b0;
      end
    end

    // Permission check
    if (access_req) begin
      if ((access_rd && !s_q.flags[page_meta_pkg::FLAG_READ]) ||
          (access_wr && !s_q.flags[page_meta_pkg::FLAG_WRITE]) ||
          (access_fetch &&
           !s_q.flags[page_meta_pkg::FLAG_EXEC])) begin
        s_d.deny = 1'b1;
      end else begin
        s_d.grant = 1'b1;
      end
    end

    unique case (s_q.st)
      ST_IDLE: begin
        if (op_start && op_kind != page_meta_pkg::OP_NONE) begin
          s_d.op = op_kind;
          s_d.off = '0;
          s_d.rec_ok = 1'b1;
          s_d.fail = 1'b0;
          mif.clear = 1'b1;
          s_d.st = ST_PAGE;
        end
      end
      ST_PAGE: begin
        if (page_valid) begin
          mif.absorb = 1'b1;
          mif.word = page_word;
          if (page_last) begin
            s_d.st = (s_q.op == page_meta_pkg::OP_EVICT) ? ST_EMIT : ST_CHECK;
          end
        end
      end
      ST_EMIT: begin
        // Evict: write record words in order, MAC words last
        s_d.ovalid = 1'b1;
        s_d.ooff = s_q.off;
        if (s_q.off == page_meta_pkg::REC_META_OFF) begin
          s_d.oword = s_q.flags;
        end else if (s_q.off == page_meta_pkg::REC_ID_OFF) begin
          s_d.oword = enclave_id;
        end else if (s_q.off == page_meta_pkg::REC_MAC_OFF) begin
          s_d.oword = mif.tag[63:0];
        end else if (s_q.off == page_meta_pkg::REC_MAC_OFF +
                     page_meta_pkg::WORD_BYTES) begin
          s_d.oword = mif.tag[127:64];
        end else begin
          s_d.oword = '0;
        end
        if (s_q.off < page_meta_pkg::REC_MAC_OFF) begin
          mif.absorb = 1'b1;
          mif.word = s_d.oword;
        end
        s_d.off = s_q.off + page_meta_pkg::WORD_BYTES;
        if (s_q.off == page_meta_pkg::REC_BYTES -
            page_meta_pkg::WORD_BYTES) begin
          s_d.st = ST_FINISH;
        end
      end
      ST_CHECK: begin
        // Reload: absorb stored record, compare stored code
        if (rec_in_valid) begin
          if (s_q.off < page_meta_pkg::REC_MAC_OFF) begin
            mif.absorb = 1'b1;
            mif.word = rec_in_word;
            if (s_q.off == page_meta_pkg::REC_META_OFF) begin
              s_d.flags = rec_in_word;
            end else if (s_q.off >= page_meta_pkg::REC_RSVD_OFF &&
                         rec_in_word != '0) begin
              s_d.rec_ok = 1'b0;
            end
          end else if (s_q.off == page_meta_pkg::REC_MAC_OFF) begin
            s_d.mac_got[63:0] = rec_in_word;
          end else begin
            s_d.mac_got[127:64] = rec_in_word;
          end
          s_d.off = s_q.off + page_meta_pkg::WORD_BYTES;
          if (s_q.off == page_meta_pkg::REC_BYTES -
              page_meta_pkg::WORD_BYTES) begin
            s_d.st = ST_FINISH;
          end
        end
      end
      ST_FINISH: begin
        s_d.done = 1'b1;
        if (s_q.op != page_meta_pkg::OP_EVICT) begin
          s_d.fail = !s_q.rec_ok || (s_q.mac_got != mif.tag);
        end
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Busy leaves a flip-flop, in step with the state
    s_d.busy = (s_d.st != ST_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each a field of the state register
  assign linear_addr = s_q.lin;
  assign source_ptr = s_q.src;
  assign meta_ptr = s_q.mptr;
  assign ctrl_page_addr = s_q.cptr;
  assign meta_ok = s_q.ok;
  assign pending = s_q.pend;
  assign modified = s_q.mod;
  assign perm_restrict_busy = s_q.prb;
  assign page_kind = s_q.kind;
  assign access_grant = s_q.grant;
  assign access_deny = s_q.deny;
  assign rec_out_valid = s_q.ovalid;
  assign rec_out_off = s_q.ooff;
  assign rec_out_word = s_q.oword;
  assign op_busy = s_q.busy;
  assign op_done = s_q.done;
  assign op_fail = s_q.fail;
endmodule // enclave_page_metadata

/* File: hdl/page_meta_pkg.sv */
/*
  Constants and types for the enclave page metadata checker: descriptor,
  security metadata and paging crypto record layouts, flag fields and
  page-kind codes.
  Assumes byte offsets within in-memory structures fed as 64-bit words.
*/
package page_meta_pkg;
  // Page-operation descriptor byte offsets
  localparam logic [7:0] DESC_LIN_OFF = 8'h00;
  localparam logic [7:0] DESC_SRC_OFF = 8'h08;
  localparam logic [7:0] DESC_META_OFF = 8'h10;
  localparam logic [7:0] DESC_CTRL_OFF = 8'h18;
  localparam logic [7:0] DESC_BYTES = 8'h20;
  // Security metadata layout
  localparam logic [7:0] META_FLAGS_OFF = 8'h00;
  localparam logic [7:0] META_RSVD_OFF = 8'h08;
  localparam logic [7:0] META_BYTES = 8'h40;
  // Paging crypto record layout
  localparam logic [7:0] REC_META_OFF = 8'h00;
  localparam logic [7:0] REC_ID_OFF = 8'h40;
  localparam logic [7:0] REC_RSVD_OFF = 8'h48;
  localparam logic [7:0] REC_MAC_OFF = 8'h70;
  localparam logic [7:0] REC_BYTES = 8'h80;
  localparam logic [7:0] WORD_BYTES = 8'h08;
  // Flag bit positions
  localparam int FLAG_READ = 0;
  localparam int FLAG_WRITE = 1;
  localparam int FLAG_EXEC = 2;
  localparam int FLAG_PENDING = 3;
  localparam int FLAG_MODIFIED = 4;
  localparam int FLAG_RESTRICT_BUSY = 5;
  localparam int KIND_LSB = 8;
  localparam logic [63:0] FLAG_RSVD_MASK = 64'hffff_ffff_ffff_00c0;
  // Page-kind codes
  localparam logic [7:0] KIND_CONTROL_PAGE = 8'h00;
  localparam logic [7:0] KIND_THREAD_CTRL_PAGE = 8'h01;
  localparam logic [7:0] KIND_REGULAR_PAGE = 8'h02;
  localparam logic [7:0] KIND_VERSION_ARRAY = 8'h03;
  localparam logic [7:0] KIND_TRIMMED = 8'h04;
  localparam logic [7:0] KIND_SHADOW_STACK_HEAD = 8'h05;
  localparam logic [7:0] KIND_SHADOW_STACK_TAIL = 8'h06;

  typedef enum logic [2:0] {
    PK_CONTROL, PK_THREAD, PK_REGULAR, PK_VERSION, PK_TRIMMED,
    PK_SS_HEAD, PK_SS_TAIL, PK_RESERVED
  } page_kind_t;

  typedef enum logic [1:0] {
    OP_EVICT, OP_RELOAD_BLOCKED, OP_RELOAD_UNBLOCKED, OP_NONE
  } page_op_t;
endpackage

/* File: hdl/mac_if.sv */
/*
  Link between the record sequencer and the authentication accumulator.
  Assumes both ends run on one clock.
*/
interface mac_if;
  logic clear;
  logic absorb;
  logic [63:0] word;
  logic [127:0] tag;
  modport seq (output clear, output absorb, output word, input tag);
  modport acc (input clear, input absorb, input word, output tag);
endinterface

/* File: hdl/page_mac_accum.sv */
/*
  Authentication accumulator: keyed mixing of absorbed 64-bit words into a
  128-bit tag. Stand-in for the real keyed function.
  Assumes a key from a secure source on its port.
*/
module page_mac_accum (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [127:0] key,
  mac_if.acc m
);
  typedef struct packed {
    logic [127:0] tag;
  } acc_state_t;
  acc_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (m.clear) begin
      s_d.tag = key;
    end else if (m.absorb) begin
      s_d.tag = {s_q.tag[126:0], s_q.tag[127]} ^
                {m.word ^ key[63:0], ~m.word ^ key[127:64]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign m.tag = s_q.tag;
endmodule // page_mac_accum

/* File: dv/enclave_page_metadata_monitor.sv */
/* Port checker for enclave_page_metadata.
   Assumes one clock and a bind into the top module. */
module enclave_page_metadata_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic meta_valid,
  input wire logic [7:0] meta_off,
  input wire logic [63:0] meta_word,
  input wire logic access_req,
  input wire logic access_rd,
  input wire logic access_wr,
  input wire logic access_fetch,
  input wire logic [63:0] enclave_id,
  input wire logic pending,
  input wire logic modified,
  input wire logic perm_restrict_busy,
  input wire logic access_grant,
  input wire logic access_deny,
  input wire logic rec_out_valid,
  input wire logic [7:0] rec_out_off,
  input wire logic [63:0] rec_out_word,
  input wire logic op_busy,
  input wire logic op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow of the accepted flag bits
  logic [5:0] flags_q;
  logic [5:0] flags_d;
  always_comb begin
    flags_d = flags_q;
    if (meta_valid && meta_off == 8'h00 && !op_busy) begin
      flags_d = meta_word[5:0];
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= 6'h00;
    end else begin
      flags_q <= flags_d;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence rec_tail;
    rec_out_valid && rec_out_off == 8'h78;
  endsequence
  sequence rec_step;
    rec_out_valid && rec_out_off != 8'h78;
  endsequence
  chk_answer_once:
    assert property (access_req |=> access_grant != access_deny)
    else $error("access answer missing or doubled");
  chk_read_deny:
    assert property (access_req && access_rd && !flags_q[0] |=> access_deny)
    else $error("read not denied");
  chk_write_deny:
    assert property (access_req && access_wr && !flags_q[1] |=> access_deny)
    else $error("write not denied");
  chk_fetch_deny:
    assert property (access_req && access_fetch && !flags_q[2] |=> access_deny)
    else $error("fetch not denied");
  chk_status_follow:
    assert property (flags_q == $past(flags_q) && flags_q == $past(flags_q, 2)
      |-> {perm_restrict_busy, modified, pending} == flags_q[5:3])
    else $error("status outputs do not follow flags");
  chk_rec_order:
    assert property (rec_step |=> rec_out_valid &&
      rec_out_off == $past(rec_out_off) + 8'h08)
    else $error("record words not consecutive");
  chk_rec_start:
    assert property ($rose(rec_out_valid) |-> rec_out_off == 8'h00)
    else $error("record does not start at offset zero");
  chk_done_after:
    assert property (rec_tail |=> op_done)
    else $error("done missing after last record word");
  chk_rec_zero:
    assert property (rec_out_valid &&
      rec_out_off inside {[8'h08:8'h38], [8'h48:8'h68]} |->
      rec_out_word == 64'h0)
    else $error("reserved record word not zero");
  chk_rec_ident:
    assert property (rec_out_valid && rec_out_off == 8'h40 |->
      rec_out_word == enclave_id)
    else $error("identifier word wrong");
endmodule // enclave_page_metadata_monitor

bind enclave_page_metadata enclave_page_metadata_monitor
  enclave_page_metadata_monitor_i (.clk, .rst_b, .meta_valid, .meta_off,
  .meta_word, .access_req, .access_rd, .access_wr, .access_fetch, .enclave_id,
  .pending, .modified, .perm_restrict_busy, .access_grant, .access_deny,
  .rec_out_valid, .rec_out_off, .rec_out_word, .op_busy, .op_done);

/* File: dv/tb_enclave_page_metadata.sv */
/* Self-checking bench for enclave_page_metadata.
   Assumes the port checker is bound in from its own file. */
module tb_enclave_page_metadata;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, shadow_stack_cap, desc_valid, meta_valid, access_req;
  logic access_rd, access_wr, access_fetch, op_start, page_valid, page_last;
  logic rec_in_valid, meta_ok, pending, modified, perm_restrict_busy;
  logic access_grant, access_deny, rec_out_valid, op_busy, op_done, op_fail;
  logic [7:0] desc_off, meta_off, rec_out_off;
  logic [63:0] desc_word, meta_word, enclave_id, page_word, rec_in_word;
  logic [63:0] linear_addr, source_ptr, meta_ptr, ctrl_page_addr, rec_out_word;
  logic [63:0] rec [16];
  page_meta_pkg::page_op_t op_kind;
  page_meta_pkg::page_kind_t page_kind;
  int err_count = 0;
  int tests_run = 0;

  enclave_page_metadata enclave_page_metadata_i (.clk, .rst_b,
    .mac_key(128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0), .shadow_stack_cap,
    .desc_valid, .desc_off, .desc_word, .meta_valid, .meta_off, .meta_word,
    .access_req, .access_rd, .access_wr, .access_fetch, .op_start, .op_kind,
    .enclave_id, .page_valid, .page_word, .page_last, .rec_in_valid,
    .rec_in_word, .linear_addr, .source_ptr, .meta_ptr, .ctrl_page_addr,
    .meta_ok, .pending, .modified, .perm_restrict_busy, .page_kind,
    .access_grant, .access_deny, .rec_out_valid, .rec_out_off, .rec_out_word,
    .op_busy, .op_done, .op_fail);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic load_meta(input logic [63:0] flags, input logic [63:0] rsvd);
    meta_valid = 1'b1;
    for (int i = 0; i < 8; i++) begin
      meta_off = 8'(i * 8);
      meta_word = (i == 0) ? flags : ((i == 7) ? rsvd : 64'h0);
      tick;
    end
    meta_valid = 1'b0;
    repeat (3) tick;
  endtask
  ////////////////////////////////////////
  task automatic t_desc;
    desc_valid = 1'b1;
    for (int i = 0; i < 5; i++) begin
      desc_off = 8'(i * 8);
      desc_word = 64'hd5c0_0000_0000_0000 + 64'(i);
      tick;
    end
    desc_valid = 1'b0;
    tick;
    chk(linear_addr, 64'hd5c0_0000_0000_0000);
    chk(source_ptr, 64'hd5c0_0000_0000_0001);
    chk(meta_ptr, 64'hd5c0_0000_0000_0002);
    chk(ctrl_page_addr, 64'hd5c0_0000_0000_0003);
  endtask
  task automatic t_kinds;
    logic [63:0] e;
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 9; k++) begin
        shadow_stack_cap = c[0];
        load_meta({48'h0, 8'(k), 8'h38}, 64'h0);
        e = (k < 5 || (k < 7 && c == 1)) ? 64'(k) : 64'h7;
        chk(page_kind, e);
        chk(meta_ok, 64'(e != 64'h7));
      end
    end
  endtask
  task automatic t_status;
    int bp [7] = '{3, 4, 5, 6, 7, 16, 63};
    for (int i = 0; i < 7; i++) begin
      load_meta(64'h200 | (64'h1 << bp[i]), 64'h0);
      chk({perm_restrict_busy, modified, pending},
        (i < 3) ? 64'h1 << i : 64'h0);
      chk(meta_ok, (i < 3) ? 64'h1 : 64'h0);
    end
    load_meta(64'h200, 64'h1);
    chk(meta_ok, 64'h0);
  endtask
  task automatic t_access;
    int n;
    for (int p = 0; p < 8; p++) begin
      load_meta(64'h200 | 64'(p), 64'h0);
      for (int s = 0; s < 3; s++) begin
        {access_fetch, access_wr, access_rd} = 3'(1 << s);
        access_req = 1'b1;
        tick;
        access_req = 1'b0;
        n = 0;
        while (access_grant !== 1'b1 && access_deny !== 1'b1 && n < 3) begin
          tick;
          n++;
        end
        chk(access_grant, 64'(p[s]));
        chk(access_deny, 64'(!p[s]));
        tick;
      end
    end
  endtask
  task automatic run_op(input page_meta_pkg::page_op_t k, input int bad);
    logic [63:0] r [16];
    int n;
    r = rec;
    n = 0;
    if (bad == 2) r[9] = 64'h1;
    if (bad == 3) r[14] ^= 64'h80;
    if (bad == 4) r[0] ^= 64'h2;
    op_kind = k;
    op_start = 1'b1;
    tick;
    op_start = 1'b0;
    chk(op_busy, 64'h1);
    page_valid = 1'b1;
    for (int i = 0; i < 4; i++) begin
      page_word = (64'h9a9e_0000_0000_0000 + 64'(i)) ^
        ((bad == 1 && i == 2) ? 64'h10 : 64'h0);
      page_last = (i == 3);
      tick;
    end
    page_valid = 1'b0;
    page_last = 1'b0;
    if (k == page_meta_pkg::OP_EVICT) begin
      for (int t = 0; t < 40 && op_done !== 1'b1; t++) begin
        if (rec_out_valid === 1'b1) begin
          chk(rec_out_off, 64'(n * 8));
          rec[n % 16] = rec_out_word;
          n++;
        end
        tick;
      end
      chk(64'(n), 64'h10);
      chk(rec[0], 64'h207);
      chk(rec[8], enclave_id);
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (i == 5) begin
          rec_in_valid = 1'b0;
          tick;
        end
        rec_in_valid = 1'b1;
        rec_in_word = r[i];
        tick;
      end
      rec_in_valid = 1'b0;
      for (int t = 0; t < 10 && op_done !== 1'b1; t++) begin
        tick;
      end
    end
    chk(op_done, 64'h1);
    chk(op_fail, 64'(k != page_meta_pkg::OP_EVICT && bad != 0));
    chk(op_busy, 64'h0);
    tick;
  endtask
  ////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    shadow_stack_cap = 1'b0;
    {desc_valid, meta_valid, access_req, access_rd, access_wr} = 5'h0;
    {access_fetch, op_start, page_valid, page_last, rec_in_valid} = 5'h0;
    {desc_off, meta_off} = 16'h0;
    {desc_word, meta_word, page_word, rec_in_word} = 256'h0;
    enclave_id = 64'h3c3c_0000_e1c1_a5e5;
    op_kind = page_meta_pkg::OP_NONE;
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk(meta_ok, 64'h0);
    chk(op_busy, 64'h0);
    tick;
    t_desc;
    t_kinds;
    t_status;
    t_access;
    load_meta(64'h207, 64'h0);
    run_op(page_meta_pkg::OP_EVICT, 0);
    for (int b = 0; b < 5; b++) begin
      run_op(b[0] ? page_meta_pkg::OP_RELOAD_BLOCKED :
        page_meta_pkg::OP_RELOAD_UNBLOCKED, b);
    end
    stop_test;
  end
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
endmodule // tb_enclave_page_metadata
